// ---- pkg/lapc_params.svh ----
// Purpose: offsets, field positions, masks and reset values of the control group
// Assumes: 8-bit register port, byte offsets as printed
// Notes: definitions only
`ifndef LAPC_PARAMS_SVH
`define LAPC_PARAMS_SVH

`define LAPC_ADDR_W 8
`define LAPC_DATA_W 8

`define LAPC_OFS_AUDIO 8'h09
`define LAPC_OFS_IMPED 8'h0A
`define LAPC_OFS_HYBRID 8'h0B
`define LAPC_OFS_PWRDN 8'h0E

`define LAPC_RST_AUDIO 8'h00
`define LAPC_RST_IMPED 8'h08
`define LAPC_RST_HYBRID 8'h33
`define LAPC_RST_PWRDN 8'h10

// writable bits of each register; other bits read zero, except power bit 4, fixed at one without a converter
`define LAPC_MSK_AUDIO 8'hFF
`define LAPC_MSK_IMPED 8'h3F
`define LAPC_MSK_HYBRID 8'h77
`define LAPC_MSK_PWRDN_CONV 8'h3B
`define LAPC_MSK_PWRDN_NOCONV 8'h2B
`define LAPC_FIX_PWRDN_NOCONV 8'h10
`define LAPC_NONE 8'h00

// audio gain fields
`define LAPC_AG_RX_BYP 7
`define LAPC_AG_TX_BYP 6
`define LAPC_AG_TX_MUTE 5
`define LAPC_AG_RX_MUTE 4
`define LAPC_AG_TX_GAIN_HI 3
`define LAPC_AG_TX_GAIN_LO 2
`define LAPC_AG_RX_GAIN_HI 1
`define LAPC_AG_RX_GAIN_LO 0

// impedance fields
`define LAPC_IM_CAP_HI 5
`define LAPC_IM_CAP_LO 4
`define LAPC_IM_EN 3
`define LAPC_IM_SEL_HI 2
`define LAPC_IM_SEL_LO 0

// hybrid fields
`define LAPC_HY_MET_HI 6
`define LAPC_HY_MET_LO 4
`define LAPC_HY_AUD_HI 2
`define LAPC_HY_AUD_LO 0
`define LAPC_HYB_OFF_CODE 3'h7

// power-down fields
`define LAPC_PD_MET_ON 5
`define LAPC_PD_CONV_OFF 4
`define LAPC_PD_MON_OFF 3
`define LAPC_PD_BIAS_OFF 1
`define LAPC_PD_DRV_OFF 0

`endif

// ---- pkg/lapc_pkg.sv ----
// Purpose: shared types of the control group
// Assumes: field layouts in lapc_params.svh
// Notes: encodings follow the register fields
package lapc_pkg;

    typedef enum logic [1:0] {
        LAPC_GAIN_UNITY = 2'h0,
        LAPC_GAIN_CUT = 2'h1,
        LAPC_GAIN_BOOST = 2'h2,
        LAPC_GAIN_MUTE = 2'h3
    } lapc_gain_type;

    typedef enum logic [1:0] {
        LAPC_CAP_OFF = 2'h0,
        LAPC_CAP_4N7 = 2'h1,
        LAPC_CAP_10N = 2'h2,
        LAPC_CAP_RSVD = 2'h3
    } lapc_cap_type;

    typedef enum logic [2:0] {
        LAPC_IMP_600 = 3'h0,
        LAPC_IMP_900 = 3'h1,
        LAPC_IMP_600_C = 3'h2,
        LAPC_IMP_900_C = 3'h3,
        LAPC_IMP_NET4 = 3'h4,
        LAPC_IMP_NET5 = 3'h5,
        LAPC_IMP_NET6 = 3'h6,
        LAPC_IMP_NET7 = 3'h7
    } lapc_imp_type;

endpackage : lapc_pkg

// ---- hw/lapc_field_reg.sv ----
// Purpose: one 8-bit control register with write mask and fixed-one bits
// Assumes: synchronous active-low reset, clock enable freezes state
// Notes: masked-off bits store nothing and read as the fixed pattern
`timescale 1ns/1ps
`default_nettype none
module lapc_field_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF,
    parameter logic [7:0] FIXED_ONES = 8'h00
) (
    input wire logic clock,
    input wire logic clk_en,
    input wire logic rst_n,
    input wire logic wr_hit,
    input wire logic [7:0] wdata,
    output logic [7:0] value
);

    logic [7:0] store_r;
    logic [7:0] store_nxt;

    // writes to reserved or fixed bits are dropped
    assign store_nxt = wr_hit ? (wdata & WR_MASK) : store_r;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            store_r <= RESET_VAL & WR_MASK;
        end else if (clk_en) begin
            store_r <= store_nxt;
        end
    end

    // reserved bits read zero, fixed bits read one
    assign value = (store_r & WR_MASK) | FIXED_ONES;

endmodule : lapc_field_reg
`default_nettype wire

// ---- hw/lapc_regs.sv ----
// Purpose: audio path, impedance, hybrid and power-override control registers
// Assumes: 8-bit register port on the same clock, master never waits
// Notes: decoded controls are registered, one cycle behind the register
`timescale 1ns/1ps
`default_nettype none
`include "lapc_params.svh"

// How it works
// - audio gain bit 7 set bypasses the receive high-pass filter.
// - audio gain bit 6 set bypasses the transmit high-pass filter.
// - transmit digital mute bit 5 set silences the transmit signal.
// - receive digital mute bit 4 set silences the receive signal.
// - transmit gain field: unity, cut, boost, or unity with path muted.
// - receive gain field: unity, cut, boost, or analog receive path muted.
// - capacitance field: off, 4.7 nF, 10 nF; code 11 not to be used.
// - impedance register bit 3 enables two-wire impedance synthesis.
// - three-bit field picks one of eight termination presets.
// - metering hybrid field steps balance; code 111 switches it off.
// - audio hybrid field uses same scale; code 111 turns it off.
// - hybrid register resets to both fields at code 011.
// - power bit 5 set forces the metering converter on.
// - with a dc-dc converter, bit 4 set forces it off.
// - without a converter, bit 4 always reads one, writes ignored.
// - power bit 3 set forces the monitoring converter off.
// - power bit 1 set forces the dc bias circuitry off.
// - power bit 0 set forces the line driver circuitry off.
// - every reserved bit reads back as zero.
module lapc_regs
    import lapc_pkg::*;
#(
    parameter bit HAS_CONVERTER = 1'b1
) (
    input wire logic clock,
    input wire logic clk_en,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    output logic rx_filter_bypass,
    output logic tx_filter_bypass,
    output logic tx_digital_mute,
    output logic rx_digital_mute,
    output logic tx_gain_cut,
    output logic tx_gain_boost,
    output logic tx_analog_mute,
    output logic rx_gain_cut,
    output logic rx_gain_boost,
    output logic rx_analog_mute,
    output logic line_cap_comp_4n7,
    output logic line_cap_comp_10n,
    output logic impedance_synth_en,
    output logic [2:0] impedance_preset_sel,
    output logic [2:0] metering_hybrid_sel,
    output logic metering_hybrid_off,
    output logic [2:0] audio_hybrid_sel,
    output logic audio_hybrid_off,
    output logic metering_dac_force_on,
    output logic converter_force_off,
    output logic monitor_adc_force_off,
    output logic bias_force_off,
    output logic line_driver_force_off
);

    localparam logic [7:0] PWR_MASK = HAS_CONVERTER ? `LAPC_MSK_PWRDN_CONV
                                                    : `LAPC_MSK_PWRDN_NOCONV;
    localparam logic [7:0] PWR_FIXED = HAS_CONVERTER ? `LAPC_NONE
                                                     : `LAPC_FIX_PWRDN_NOCONV;

    // address decode
    wire logic sel_audio;
    wire logic sel_imped;
    wire logic sel_hybrid;
    wire logic sel_pwrdn;
    assign sel_audio = (addr == `LAPC_OFS_AUDIO);
    assign sel_imped = (addr == `LAPC_OFS_IMPED);
    assign sel_hybrid = (addr == `LAPC_OFS_HYBRID);
    assign sel_pwrdn = (addr == `LAPC_OFS_PWRDN);

    wire logic wr_audio;
    wire logic wr_imped;
    wire logic wr_hybrid;
    wire logic wr_pwrdn;
    assign wr_audio = wr_en && sel_audio;
    assign wr_imped = wr_en && sel_imped;
    assign wr_hybrid = wr_en && sel_hybrid;
    assign wr_pwrdn = wr_en && sel_pwrdn;

    wire logic [7:0] audio_val;
    wire logic [7:0] imped_val;
    wire logic [7:0] hybrid_val;
    wire logic [7:0] pwrdn_val;

    lapc_field_reg #(
        .RESET_VAL(`LAPC_RST_AUDIO),
        .WR_MASK(`LAPC_MSK_AUDIO),
        .FIXED_ONES(`LAPC_NONE)
    ) u_audio (
        .clock(clock),
        .clk_en(clk_en),
        .rst_n(rst_n),
        .wr_hit(wr_audio),
        .wdata(wdata),
        .value(audio_val)
    );

    lapc_field_reg #(
        .RESET_VAL(`LAPC_RST_IMPED),
        .WR_MASK(`LAPC_MSK_IMPED),
        .FIXED_ONES(`LAPC_NONE)
    ) u_imped (
        .clock(clock),
        .clk_en(clk_en),
        .rst_n(rst_n),
        .wr_hit(wr_imped),
        .wdata(wdata),
        .value(imped_val)
    );

    // both hybrid fields start at the 0 dB code
    lapc_field_reg #(
        .RESET_VAL(`LAPC_RST_HYBRID),
        .WR_MASK(`LAPC_MSK_HYBRID),
        .FIXED_ONES(`LAPC_NONE)
    ) u_hybrid (
        .clock(clock),
        .clk_en(clk_en),
        .rst_n(rst_n),
        .wr_hit(wr_hybrid),
        .wdata(wdata),
        .value(hybrid_val)
    );

    // converter bit is fixed at one on the variant without it
    lapc_field_reg #(
        .RESET_VAL(`LAPC_RST_PWRDN),
        .WR_MASK(PWR_MASK),
        .FIXED_ONES(PWR_FIXED)
    ) u_pwrdn (
        .clock(clock),
        .clk_en(clk_en),
        .rst_n(rst_n),
        .wr_hit(wr_pwrdn),
        .wdata(wdata),
        .value(pwrdn_val)
    );

    // read mux, unmapped offsets read zero
    wire logic [7:0] rd_mux;
    assign rd_mux = sel_audio ? audio_val :
                    sel_imped ? imped_val :
                    sel_hybrid ? hybrid_val :
                    sel_pwrdn ? pwrdn_val : 8'h00;

    // field decode
    lapc_gain_type tx_gain;
    lapc_gain_type rx_gain;
    lapc_cap_type cap_sel;
    wire logic [2:0] met_code;
    wire logic [2:0] aud_code;
    assign tx_gain = lapc_gain_type'(audio_val[`LAPC_AG_TX_GAIN_HI:`LAPC_AG_TX_GAIN_LO]);
    assign rx_gain = lapc_gain_type'(audio_val[`LAPC_AG_RX_GAIN_HI:`LAPC_AG_RX_GAIN_LO]);
    assign cap_sel = lapc_cap_type'(imped_val[`LAPC_IM_CAP_HI:`LAPC_IM_CAP_LO]);
    assign met_code = hybrid_val[`LAPC_HY_MET_HI:`LAPC_HY_MET_LO];
    assign aud_code = hybrid_val[`LAPC_HY_AUD_HI:`LAPC_HY_AUD_LO];

    wire logic tx_cut_nxt;
    wire logic tx_boost_nxt;
    wire logic tx_amute_nxt;
    wire logic rx_cut_nxt;
    wire logic rx_boost_nxt;
    wire logic rx_amute_nxt;
    // mute code keeps unity gain with the path silenced
    assign tx_cut_nxt = (tx_gain == LAPC_GAIN_CUT);
    assign tx_boost_nxt = (tx_gain == LAPC_GAIN_BOOST);
    assign tx_amute_nxt = (tx_gain == LAPC_GAIN_MUTE);
    assign rx_cut_nxt = (rx_gain == LAPC_GAIN_CUT);
    assign rx_boost_nxt = (rx_gain == LAPC_GAIN_BOOST);
    assign rx_amute_nxt = (rx_gain == LAPC_GAIN_MUTE);

    // reserved capacitance code leaves compensation off
    wire logic cap_4n7_nxt;
    wire logic cap_10n_nxt;
    assign cap_4n7_nxt = (cap_sel == LAPC_CAP_4N7);
    assign cap_10n_nxt = (cap_sel == LAPC_CAP_10N);

    wire logic met_off_nxt;
    wire logic aud_off_nxt;
    assign met_off_nxt = (met_code == `LAPC_HYB_OFF_CODE);
    assign aud_off_nxt = (aud_code == `LAPC_HYB_OFF_CODE);

    wire logic conv_off_nxt;
    assign conv_off_nxt = pwrdn_val[`LAPC_PD_CONV_OFF];

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (clk_en) begin
            rdata <= rd_en ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_filter_bypass <= 1'b0;
            tx_filter_bypass <= 1'b0;
            tx_digital_mute <= 1'b0;
            rx_digital_mute <= 1'b0;
        end else if (clk_en) begin
            rx_filter_bypass <= audio_val[`LAPC_AG_RX_BYP];
            tx_filter_bypass <= audio_val[`LAPC_AG_TX_BYP];
            tx_digital_mute <= audio_val[`LAPC_AG_TX_MUTE];
            rx_digital_mute <= audio_val[`LAPC_AG_RX_MUTE];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_gain_cut <= 1'b0;
            tx_gain_boost <= 1'b0;
            tx_analog_mute <= 1'b0;
            rx_gain_cut <= 1'b0;
            rx_gain_boost <= 1'b0;
            rx_analog_mute <= 1'b0;
        end else if (clk_en) begin
            tx_gain_cut <= tx_cut_nxt;
            tx_gain_boost <= tx_boost_nxt;
            tx_analog_mute <= tx_amute_nxt;
            rx_gain_cut <= rx_cut_nxt;
            rx_gain_boost <= rx_boost_nxt;
            rx_analog_mute <= rx_amute_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            line_cap_comp_4n7 <= 1'b0;
            line_cap_comp_10n <= 1'b0;
            impedance_synth_en <= 1'b1;
            impedance_preset_sel <= 3'h0;
        end else if (clk_en) begin
            line_cap_comp_4n7 <= cap_4n7_nxt;
            line_cap_comp_10n <= cap_10n_nxt;
            impedance_synth_en <= imped_val[`LAPC_IM_EN];
            impedance_preset_sel <= imped_val[`LAPC_IM_SEL_HI:`LAPC_IM_SEL_LO];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            metering_hybrid_sel <= 3'h3;
            metering_hybrid_off <= 1'b0;
            audio_hybrid_sel <= 3'h3;
            audio_hybrid_off <= 1'b0;
        end else if (clk_en) begin
            metering_hybrid_sel <= met_code;
            metering_hybrid_off <= met_off_nxt;
            audio_hybrid_sel <= aud_code;
            audio_hybrid_off <= aud_off_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            metering_dac_force_on <= 1'b0;
            converter_force_off <= 1'b1;
            monitor_adc_force_off <= 1'b0;
            bias_force_off <= 1'b0;
            line_driver_force_off <= 1'b0;
        end else if (clk_en) begin
            metering_dac_force_on <= pwrdn_val[`LAPC_PD_MET_ON];
            converter_force_off <= conv_off_nxt;
            monitor_adc_force_off <= pwrdn_val[`LAPC_PD_MON_OFF];
            bias_force_off <= pwrdn_val[`LAPC_PD_BIAS_OFF];
            line_driver_force_off <= pwrdn_val[`LAPC_PD_DRV_OFF];
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_rx_bypass_follow: assert property (
        (clk_en && wr_audio) ##1 clk_en |=> rx_filter_bypass == $past(wdata[7], 2)
    ) else $error("rx filter bypass does not follow write");

    chk_tx_bypass_follow: assert property (
        (clk_en && wr_audio) ##1 clk_en |=> tx_filter_bypass == $past(wdata[6], 2)
    ) else $error("tx filter bypass does not follow write");

    chk_mute_pair: assert property (
        (clk_en && wr_audio && wdata[5] && !wdata[4]) ##1 clk_en
            |=> tx_digital_mute && !rx_digital_mute
    ) else $error("digital mute bits swapped or lost");

    chk_rx_mute_clear: assert property (
        (clk_en && wr_audio && !wdata[4]) ##1 clk_en |=> !rx_digital_mute
    ) else $error("rx digital mute stuck");

    chk_tx_gain_mute: assert property (
        tx_analog_mute |-> !tx_gain_cut && !tx_gain_boost
    ) else $error("tx analog mute with gain step");

    chk_rx_gain_code: assert property (
        (clk_en && wr_audio && wdata[1:0] == 2'h2) ##1 clk_en
            |=> rx_gain_boost && !rx_gain_cut && !rx_analog_mute
    ) else $error("rx boost code not decoded");

    chk_cap_exclusive: assert property (
        !(line_cap_comp_4n7 && line_cap_comp_10n)
    ) else $error("both capacitance steps on");

    chk_imped_readback: assert property (
        (clk_en && wr_imped) ##1 (clk_en && rd_en && sel_imped)
            |=> rdata == {2'h0, $past(wdata[5:0], 2)}
    ) else $error("impedance register readback wrong");

    chk_hybrid_reset: assert property (
        !$past(rst_n) |-> hybrid_val == `LAPC_RST_HYBRID
    ) else $error("hybrid register reset value wrong");

    chk_hyb_off_code: assert property (
        audio_hybrid_off == (audio_hybrid_sel == `LAPC_HYB_OFF_CODE)
    ) else $error("audio hybrid off flag mismatch");

    chk_conv_fixed: assert property (
        !HAS_CONVERTER |-> pwrdn_val[`LAPC_PD_CONV_OFF] && converter_force_off
    ) else $error("converter bit not fixed at one");

    chk_resv_zero: assert property (
        (clk_en && rd_en && sel_hybrid) |=> rdata[7] == 1'b0 && rdata[3] == 1'b0
    ) else $error("reserved hybrid bits read nonzero");

    chk_unmapped_zero: assert property (
        (clk_en && rd_en && !(sel_audio || sel_imped || sel_hybrid || sel_pwrdn))
            |=> rdata == 8'h00
    ) else $error("unmapped read nonzero");

    chk_drv_off_follow: assert property (
        (clk_en && wr_pwrdn) ##1 clk_en |=> line_driver_force_off == $past(wdata[0], 2)
    ) else $error("line driver override not applied");

    cov_audio_write: cover property (clk_en && wr_audio && wdata == 8'hFF);
    cov_hybrid_off: cover property (metering_hybrid_off && audio_hybrid_off);
    cov_write_read: cover property ((clk_en && wr_pwrdn) ##1 (clk_en && rd_en && sel_pwrdn));
    cov_freeze: cover property (!clk_en && wr_en);

endmodule : lapc_regs
`default_nettype wire

// ---- tb/test_line_audio_power_control_regs.sv ----
// Purpose: register-level test of the line audio and power control group
// Assumes: one-cycle strobes, read data stands only in the cycle after the read strobe
// Notes: both variants, with and without converter, share one register port
`timescale 1ns/1ps
`default_nettype none
`include "lapc_params.svh"
module test_line_audio_power_control_regs import lapc_pkg::*;;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    wire logic [7:0] rdat [2];
    wire logic [28:0] outs [2];
    logic [7:0] m_aud;
    logic [7:0] m_imp;
    logic [7:0] m_hyb;
    logic [7:0] m_pwr;
    int n_fail = 0;
    int n_tests = 0;

    initial begin
        forever #5 clock = ~clock;
    end

    // instance 0 has the converter, instance 1 has none
    for (genvar g = 0; g < 2; g++) begin : gv
        lapc_regs #(.HAS_CONVERTER(g == 0)) dut_u (
            .clock(clock), .clk_en(clk_en), .rst_n(rst_n), .addr(addr), .wdata(wdata),
            .wr_en(wr_en), .rd_en(rd_en), .rdata(rdat[g]),
            .rx_filter_bypass(outs[g][28]), .tx_filter_bypass(outs[g][27]),
            .tx_digital_mute(outs[g][26]), .rx_digital_mute(outs[g][25]),
            .tx_gain_cut(outs[g][24]), .tx_gain_boost(outs[g][23]),
            .tx_analog_mute(outs[g][22]), .rx_gain_cut(outs[g][21]),
            .rx_gain_boost(outs[g][20]), .rx_analog_mute(outs[g][19]),
            .line_cap_comp_4n7(outs[g][18]), .line_cap_comp_10n(outs[g][17]),
            .impedance_synth_en(outs[g][16]), .impedance_preset_sel(outs[g][15:13]),
            .metering_hybrid_sel(outs[g][12:10]), .metering_hybrid_off(outs[g][9]),
            .audio_hybrid_sel(outs[g][8:6]), .audio_hybrid_off(outs[g][5]),
            .metering_dac_force_on(outs[g][4]), .converter_force_off(outs[g][3]),
            .monitor_adc_force_off(outs[g][2]), .bias_force_off(outs[g][1]),
            .line_driver_force_off(outs[g][0])
        );
    end

    function automatic logic [7:0] pwr_nc();
        return (m_pwr & 8'h2B) | 8'h10;
    endfunction : pwr_nc

    function automatic logic [28:0] exp_outs(input logic [7:0] pw);
        return {m_aud[7:4], m_aud[3:2] == 2'h1, m_aud[3:2] == 2'h2, m_aud[3:2] == 2'h3,
            m_aud[1:0] == 2'h1, m_aud[1:0] == 2'h2, m_aud[1:0] == 2'h3,
            m_imp[5:4] == 2'h1, m_imp[5:4] == 2'h2, m_imp[3], m_imp[2:0],
            m_hyb[6:4], m_hyb[6:4] == 3'h7, m_hyb[2:0], m_hyb[2:0] == 3'h7,
            pw[5], pw[4], pw[3], pw[1], pw[0]};
    endfunction : exp_outs

    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s read %h, expected %h", $time, what, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_out(input logic [28:0] got, input logic [28:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s controls %h, expected %h", $time, what, got, exp);
        end
    endtask : cmp_out

    task automatic do_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        @(posedge clock);
        rst_n <= 1'b1;
        m_aud = 8'h00;
        m_imp = 8'h08;
        m_hyb = 8'h33;
        m_pwr = 8'h10;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        if (clk_en === 1'b1) begin
            case (a)
                `LAPC_OFS_AUDIO: m_aud = d;
                `LAPC_OFS_IMPED: m_imp = d & 8'h3F;
                `LAPC_OFS_HYBRID: m_hyb = d & 8'h77;
                `LAPC_OFS_PWRDN: m_pwr = d & 8'h3B;
                default: ;
            endcase
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        cmp_reg(rdat[0], e0, "conv");
        cmp_reg(rdat[1], e1, "noconv");
        @(posedge clock);
        #1;
        cmp_reg(rdat[0] | rdat[1], 8'h00, "idle");
    endtask : rd

    // controls lag the register by one edge, then all four registers read back
    task automatic check_all();
        @(posedge clock);
        #1;
        cmp_out(outs[0], exp_outs(m_pwr), "conv");
        cmp_out(outs[1], exp_outs(pwr_nc()), "noconv");
        rd(`LAPC_OFS_AUDIO, m_aud, m_aud);
        rd(`LAPC_OFS_IMPED, m_imp, m_imp);
        rd(`LAPC_OFS_HYBRID, m_hyb, m_hyb);
        rd(`LAPC_OFS_PWRDN, m_pwr, pwr_nc());
    endtask : check_all

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    initial begin
        #100000;
        n_fail++;
        $display("mismatch at %0t: run did not finish", $time);
        conclude();
    end

    initial begin
        do_reset();
        check_all();
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(`LAPC_OFS_AUDIO, {4{i[1:0]}});
            check_all();
        end
        $display("test audio done");
        for (int i = 0; i < 8; i++) begin
            // software never programs the reserved capacitance code
            wr(`LAPC_OFS_IMPED, {2'h3, 2'(i % 3), ~i[0], i[2:0]});
            check_all();
        end
        $display("test impedance done");
        for (int i = 0; i < 8; i++) begin
            wr(`LAPC_OFS_HYBRID, {1'b1, i[2:0], 1'b1, 3'h7 - i[2:0]});
            check_all();
        end
        $display("test hybrid done");
        for (int k = 0; k < 8; k++) begin
            wr(`LAPC_OFS_PWRDN, 8'hC4 | (8'h01 << k));
            check_all();
        end
        wr(`LAPC_OFS_PWRDN, 8'h00);
        check_all();
        $display("test power done");
        // strobes with the clock enable low and unmapped offsets change nothing
        @(posedge clock);
        clk_en <= 1'b0;
        wr(`LAPC_OFS_AUDIO, 8'hAA);
        clk_en <= 1'b1;
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 8'h00, 8'h00);
        check_all();
        $display("test refused done");
        // write then read with no gap returns the new value
        for (int j = 0; j < 2; j++) begin
            @(posedge clock);
            wr_en <= 1'b1;
            addr <= j ? `LAPC_OFS_IMPED : `LAPC_OFS_AUDIO;
            wdata <= 8'h5A;
            @(posedge clock);
            wr_en <= 1'b0;
            rd_en <= 1'b1;
            @(posedge clock);
            rd_en <= 1'b0;
            #1;
            cmp_reg(rdat[0], j ? 8'h1A : 8'h5A, "conv");
        end
        m_aud = 8'h5A;
        m_imp = 8'h1A;
        check_all();
        $display("test back to back done");
        do_reset();
        check_all();
        $display("test second reset done");
        conclude();
    end

endmodule : test_line_audio_power_control_regs
`default_nettype wire
